// file: src/spmi_pkg.sv
// Package for the sixth port MII block: register map, fields, carriers.
// Assumes a 32-bit AHB-Lite bus and a 25 MHz hclk.
package spmi_pkg;
    // Register byte offsets
    localparam logic [7:0] SPMI_CTRL = 8'h00;
    localparam logic [7:0] SPMI_STATUS = 8'h04;
    localparam logic [7:0] SPMI_TX_DATA = 8'h08;
    localparam logic [7:0] SPMI_RX_DATA = 8'h0C;
    // Control fields and reset value
    localparam int SPMI_CTRL_TX_EN = 0;
    localparam logic [31:0] SPMI_CTRL_RST = 32'h0000_0000;
    // Status fields
    localparam int SPMI_ST_FLOW = 0;
    localparam int SPMI_ST_SERIAL = 1;
    localparam int SPMI_ST_ADDR = 2;
    localparam int SPMI_ST_SMALL_EE = 4;
    localparam int SPMI_ST_LINK = 5;
    localparam int SPMI_ST_FDX = 6;
    localparam int SPMI_ST_SPD100 = 7;
    localparam int SPMI_ST_CRS = 8;
    localparam int SPMI_ST_COL = 9;
    localparam int SPMI_ST_RX_OVF = 10;
    localparam int SPMI_ST_COL_SEEN = 11;
    // Receive data register: valid flag position
    localparam int SPMI_RXD_VALID = 8;
    // Straps are latched once the pin synchronisers have filled
    localparam logic [1:0] SPMI_STRAP_WAIT = 2'h3;
    localparam int SPMI_FIFO_DEPTH = 16;
    localparam int SPMI_NIB_W = 4;
    // One received nibble with its error flag
    typedef struct packed {
        logic err;
        logic [3:0] nibble;
    } spmi_rx_word_t;
    // Receive-side pins of the partner
    typedef struct packed {
        logic [3:0] nibble;
        logic valid;
        logic error;
        logic collision;
        logic carrier;
    } spmi_rx_pins_t;
endpackage : spmi_pkg

// file: src/spmi_sync.sv
// Three-stage synchroniser with settled level and rising-edge pulse.
// Assumes inputs come from outside the hclk domain.
`timescale 1ns/1ps
module spmi_sync #(
    parameter int W = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] level,
    output logic [W-1:0] rise
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    // Chain; only s2 reads s1
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
        end else begin
            s1 <= d;
            s2 <= s1;
            s3 <= s2;
        end
    end
    // Level follows once stages two and three agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level <= '0;
        end else begin
            level <= (~(s2 ^ s3) & s2) | ((s2 ^ s3) & level) | (~(s2 ^ s3) & s2);
        end
    end
    assign rise = ~(s2 ^ s3) & s2 & ~level;
endmodule : spmi_sync

// file: src/spmi_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; depth a power of two.
`timescale 1ns/1ps
module spmi_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [W-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic push;
    logic pop;
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    // Full when pointers differ only in the wrap bit
    assign in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data = mem[rd_ptr[AW-1:0]];
    // Storage
    always_ff @(posedge hclk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end
    // Pointers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule : spmi_fifo

// file: src/spmi_port.sv
// Sixth switch port on MII: AHB-Lite registers, strap capture, nibble
// transmit and receive paths with a 16-word FIFO on each side.
// Assumes link clocks and pins are asynchronous to hclk and much slower.
//
// Chosen here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
module spmi_port
    import spmi_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic port_five_tx_clock,
    input wire logic port_five_rx_clock,
    input wire logic [3:0] port_five_tx_nibble_in,
    output logic [3:0] port_five_tx_nibble,
    output logic [3:0] port_five_tx_nibble_oe,
    input wire logic port_five_tx_valid_in,
    output logic port_five_tx_valid,
    output logic port_five_tx_valid_oe,
    input wire logic [3:0] port_five_rx_nibble,
    input wire logic port_five_rx_valid,
    input wire logic port_five_rx_error,
    input wire logic port_five_collision,
    input wire logic port_five_carrier,
    input wire logic chip_addr_strap_hi,
    input wire logic port_five_duplex_in,
    input wire logic port_five_link_in,
    input wire logic port_five_speed_in,
    output logic flow_ctrl_enable,
    output logic serial_mode,
    output logic [1:0] chip_addr,
    output logic small_eeprom_master,
    output logic link_up,
    output logic full_duplex,
    output logic speed_100
);
    // Synchronised pins
    spmi_rx_pins_t rx_pins;
    spmi_rx_pins_t rx_lvl;
    logic [1:0] clk_rise;
    logic [2:0] stat_lvl;
    logic [3:0] strap_lvl;
    logic tx_rise;
    logic rx_rise;
    // Strap capture
    logic [1:0] strap_cnt;
    logic strap_done;
    logic strap_take;
    // Bus state
    logic [31:0] ctrl;
    logic [7:0] dph_addr;
    logic dph_write;
    logic pend_tx;
    logic rx_ovf;
    logic col_seen;
    // FIFOs
    spmi_rx_word_t rx_in;
    spmi_rx_word_t rx_out;
    logic rx_push;
    logic rx_in_ready;
    logic rx_out_valid;
    logic rx_pop;
    logic tx_in_ready;
    logic [3:0] tx_out;
    logic tx_out_valid;
    logic tx_pop;
    // Transmit serialiser
    logic [2:0] tx_bits;
    logic [3:0] tx_shift;
    logic tx_go;
    logic addr_ok;
    logic rd_rx;

    assign rx_pins = '{nibble: port_five_rx_nibble, valid: port_five_rx_valid,
                       error: port_five_rx_error, collision: port_five_collision,
                       carrier: port_five_carrier};

    // Receive pins, partner-driven
    // partner receive inputs
    spmi_sync #(.W(8)) u_rx_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .d(rx_pins),
        .level(rx_lvl),
        .rise()
    );

    // Link clocks sampled as plain inputs
    // clocks come from partner
    spmi_sync #(.W(2)) u_clk_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .d({port_five_tx_clock, port_five_rx_clock}),
        .level(),
        .rise(clk_rise)
    );
    assign tx_rise = clk_rise[1];
    assign rx_rise = clk_rise[0];

    // Static status pins and strap pins
    spmi_sync #(.W(7)) u_pin_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .d({port_five_duplex_in, port_five_link_in, port_five_speed_in,
            chip_addr_strap_hi, port_five_tx_valid_in,
            port_five_tx_nibble_in[1], port_five_tx_nibble_in[0]}),
        .level({stat_lvl, strap_lvl}),
        .rise()
    );

    // Strap sampling waits for the synchronisers to fill
    // capture once after reset
    // Take strobe lags one edge so the synchronised strap level has settled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            strap_cnt <= '0;
            strap_done <= 1'b0;
            strap_take <= 1'b0;
        end else begin
            strap_take <= !strap_done && strap_cnt == SPMI_STRAP_WAIT;
            if (!strap_done) begin
                strap_cnt <= strap_cnt + 1'b1;
                strap_done <= strap_cnt == SPMI_STRAP_WAIT;
            end
        end
    end

    // Strap latches, held until the next reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flow_ctrl_enable <= 1'b0;
            serial_mode <= 1'b0;
            chip_addr <= 2'h0;
            small_eeprom_master <= 1'b0;
        end else if (strap_take) begin
            flow_ctrl_enable <= strap_lvl[0];
            serial_mode <= strap_lvl[1];
            chip_addr <= {strap_lvl[3], strap_lvl[2]};
            small_eeprom_master <= strap_lvl[3:2] == 2'h0;
        end
    end

    // Static link status, active-low pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            full_duplex <= 1'b0;
            link_up <= 1'b0;
            speed_100 <= 1'b0;
        end else begin
            full_duplex <= ~stat_lvl[2];
            link_up <= ~stat_lvl[1];
            speed_100 <= ~stat_lvl[0];
        end
    end

    // Bus decode of the address phase
    assign addr_ok = hsel & hready & htrans[1];
    assign rd_rx = addr_ok & ~hwrite & haddr[7:0] == SPMI_RX_DATA;

    // Address phase capture and wait state for transmit pushes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_addr <= 8'h00;
            dph_write <= 1'b0;
            pend_tx <= 1'b0;
            hreadyout <= 1'b1;
        end else if (pend_tx) begin
            // Stall the master until the transmit FIFO has room
            if (tx_in_ready) begin
                pend_tx <= 1'b0;
                hreadyout <= 1'b1;
                dph_write <= 1'b0;
            end
        end else if (addr_ok) begin
            dph_addr <= haddr[7:0];
            dph_write <= hwrite;
            pend_tx <= hwrite & haddr[7:0] == SPMI_TX_DATA;
            hreadyout <= ~(hwrite & haddr[7:0] == SPMI_TX_DATA);
        end else begin
            dph_write <= 1'b0;
        end
    end

    // Response is always OKAY
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp <= 1'b0;
        end else begin
            hresp <= 1'b0;
        end
    end

    // Control register write in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= SPMI_CTRL_RST;
        end else if (dph_write && dph_addr == SPMI_CTRL) begin
            ctrl <= {31'h0000_0000, hwdata[SPMI_CTRL_TX_EN]};
        end
    end

    // Sticky flags; a new event wins over a write-one clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_ovf <= 1'b0;
            col_seen <= 1'b0;
        end else begin
            rx_ovf <= (rx_push & ~rx_in_ready) | (rx_ovf &
                      ~(dph_write & dph_addr == SPMI_STATUS & hwdata[SPMI_ST_RX_OVF]));
            col_seen <= (rx_lvl.collision & port_five_tx_valid & ~full_duplex) |
                        (col_seen & ~(dph_write & dph_addr == SPMI_STATUS &
                        hwdata[SPMI_ST_COL_SEEN]));
        end
    end

    // Read data registered in the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_ok && !hwrite && !pend_tx) begin
            case (haddr[7:0])
                SPMI_CTRL: hrdata <= ctrl;
                SPMI_STATUS: begin
                    hrdata <= 32'h0000_0000;
                    hrdata[SPMI_ST_FLOW] <= flow_ctrl_enable;
                    hrdata[SPMI_ST_SERIAL] <= serial_mode;
                    hrdata[SPMI_ST_ADDR +: 2] <= chip_addr;
                    hrdata[SPMI_ST_SMALL_EE] <= small_eeprom_master;
                    hrdata[SPMI_ST_LINK] <= link_up;
                    hrdata[SPMI_ST_FDX] <= full_duplex;
                    hrdata[SPMI_ST_SPD100] <= speed_100;
                    hrdata[SPMI_ST_CRS] <= rx_lvl.carrier;
                    hrdata[SPMI_ST_COL] <= rx_lvl.collision;
                    hrdata[SPMI_ST_RX_OVF] <= rx_ovf;
                    hrdata[SPMI_ST_COL_SEEN] <= col_seen;
                end
                SPMI_RX_DATA: begin
                    hrdata <= {23'h00_0000, rx_out_valid, 3'h0, rx_out};
                end
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    // Receive: sample the nibble on the receive clock rising edge
    // sample on partner edge
    assign rx_push = rx_rise & rx_lvl.valid;
    assign rx_in = '{err: rx_lvl.error, nibble: rx_lvl.nibble};
    assign rx_pop = rd_rx & ~pend_tx;

    spmi_fifo #(.W(5), .D(SPMI_FIFO_DEPTH)) u_rx_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .in_data(rx_in),
        .in_valid(rx_push),
        .in_ready(rx_in_ready),
        .out_data(rx_out),
        .out_valid(rx_out_valid),
        .out_ready(rx_pop)
    );

    spmi_fifo #(.W(SPMI_NIB_W), .D(SPMI_FIFO_DEPTH)) u_tx_fifo (
        .hclk(hclk),
        .hresetn(hresetn),
        .in_data(hwdata[3:0]),
        .in_valid(pend_tx),
        .in_ready(tx_in_ready),
        .out_data(tx_out),
        .out_valid(tx_out_valid),
        .out_ready(tx_pop)
    );

    // Transmit only when enabled, straps are in, and the link is up
    assign tx_go = ctrl[SPMI_CTRL_TX_EN] & strap_done & ~strap_take & link_up;
    assign tx_pop = tx_rise & tx_go & tx_out_valid & tx_bits == 3'h0;

    // Transmit pins driven only once straps have been sampled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_five_tx_nibble_oe <= 4'h0;
            port_five_tx_valid_oe <= 1'b0;
        end else begin
            port_five_tx_nibble_oe <= {4{strap_done & ~strap_take}};
            port_five_tx_valid_oe <= strap_done & ~strap_take;
        end
    end

    // Transmit nibble or serial bit stream on the transmit clock edge
    // update on transmit edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            port_five_tx_nibble <= 4'h0;
            port_five_tx_valid <= 1'b0;
            tx_shift <= 4'h0;
            tx_bits <= 3'h0;
        end else if (tx_rise) begin
            if (tx_bits != 3'h0) begin
                port_five_tx_nibble <= {3'h0, tx_shift[0]};
                tx_shift <= {1'b0, tx_shift[3:1]};
                tx_bits <= tx_bits - 1'b1;
            end else if (tx_pop && serial_mode) begin
                port_five_tx_nibble <= {3'h0, tx_out[0]};
                tx_shift <= {1'b0, tx_out[3:1]};
                tx_bits <= 3'h3;
                port_five_tx_valid <= 1'b1;
            end else if (tx_pop) begin
                port_five_tx_nibble <= tx_out;
                port_five_tx_valid <= 1'b1;
            end else begin
                port_five_tx_nibble <= 4'h0;
                port_five_tx_valid <= 1'b0;
            end
        end
    end
endmodule : spmi_port

// file: verif/spmi_port_sva.sv
// Concurrent checks on straps, pin status and transmit timing of the port.
// Assumes it is bound into spmi_port; the raw link clock is sampled by hclk.
`timescale 1ns/1ps
module spmi_port_sva (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic port_five_tx_clock,
    input wire logic [3:0] port_five_tx_nibble_in,
    input wire logic [3:0] port_five_tx_nibble,
    input wire logic port_five_tx_valid_in,
    input wire logic port_five_tx_valid,
    input wire logic chip_addr_strap_hi,
    input wire logic port_five_duplex_in,
    input wire logic port_five_link_in,
    input wire logic port_five_speed_in,
    input wire logic flow_ctrl_enable,
    input wire logic serial_mode,
    input wire logic [1:0] chip_addr,
    input wire logic small_eeprom_master,
    input wire logic link_up,
    input wire logic full_duplex,
    input wire logic speed_100
);
    logic [2:0] rel_cnt;
    logic [2:0] since_tx;
    logic tx_d;
    logic [3:0] strap_ref;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Edges since reset release, saturating once straps must be settled
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rel_cnt <= 3'h0;
        end else if (rel_cnt != 3'h7) begin
            rel_cnt <= rel_cnt + 3'h1;
        end
    end
    // Strap pin levels seen around reset release
    always_ff @(posedge hclk) begin
        if (rel_cnt < 3'h3) begin
            strap_ref <= {chip_addr_strap_hi, port_five_tx_valid_in, port_five_tx_nibble_in[1:0]};
        end
    end
    // Edges since the last transmit clock rise
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_d <= 1'b0;
            since_tx <= 3'h7;
        end else begin
            tx_d <= port_five_tx_clock;
            if (port_five_tx_clock && !tx_d) begin
                since_tx <= 3'h0;
            end else if (since_tx != 3'h7) begin
                since_tx <= since_tx + 3'h1;
            end
        end
    end
    flow_strap_a: assert property (rel_cnt == 3'h7 |-> flow_ctrl_enable == strap_ref[0])
        else $error("flow control differs from strap");
    serial_strap_a: assert property (rel_cnt == 3'h7 |-> serial_mode == strap_ref[1])
        else $error("serial mode differs from strap");
    addr_strap_a: assert property (rel_cnt == 3'h7 |-> chip_addr == strap_ref[3:2])
        else $error("chip address differs from straps");
    small_ee_a: assert property (rel_cnt == 3'h7 |->
        small_eeprom_master == (chip_addr == 2'h0))
        else $error("small eeprom master wrong");
    strap_hold_a: assert property (rel_cnt == 3'h7 |->
        $stable({flow_ctrl_enable, serial_mode, chip_addr}))
        else $error("strap result changed");
    link_map_a: assert property (($stable(port_five_link_in))[*7] |->
        link_up == !port_five_link_in)
        else $error("link up wrong");
    duplex_map_a: assert property ($fell(port_five_duplex_in) |-> ##[1:6] full_duplex)
        else $error("full duplex late");
    speed_map_a: assert property ($rose(port_five_speed_in) |-> ##[1:6] !speed_100)
        else $error("speed not 10M");
    tx_edge_a: assert property (rel_cnt == 3'h7 &&
        $changed({port_five_tx_valid, port_five_tx_nibble}) |-> since_tx != 3'h7)
        else $error("transmit change away from clock rise");
    serial_c: cover property (serial_mode && port_five_tx_valid);
    nibble_c: cover property (!serial_mode && $rose(port_five_tx_valid));
    master_c: cover property (rel_cnt == 3'h7 && small_eeprom_master);
endmodule : spmi_port_sva

bind spmi_port spmi_port_sva i_sva (
    .hclk(hclk), .hresetn(hresetn), .port_five_tx_clock(port_five_tx_clock),
    .port_five_tx_nibble_in(port_five_tx_nibble_in), .port_five_tx_nibble(port_five_tx_nibble),
    .port_five_tx_valid_in(port_five_tx_valid_in), .port_five_tx_valid(port_five_tx_valid),
    .chip_addr_strap_hi(chip_addr_strap_hi), .port_five_duplex_in(port_five_duplex_in),
    .port_five_link_in(port_five_link_in), .port_five_speed_in(port_five_speed_in),
    .flow_ctrl_enable(flow_ctrl_enable), .serial_mode(serial_mode), .chip_addr(chip_addr),
    .small_eeprom_master(small_eeprom_master), .link_up(link_up),
    .full_duplex(full_duplex), .speed_100(speed_100)
);

// file: verif/spmi_mii_partner.sv
// Behavioural MII partner: link clocks, receive frames, transmit capture.
// Assumes the bench raises run before any link traffic.
`timescale 1ns/1ps
module spmi_mii_partner
    import spmi_pkg::*;
(
    input wire logic run,
    input wire logic [3:0] tx_nibble,
    input wire logic tx_valid,
    output logic tx_clock,
    output logic rx_clock,
    output spmi_rx_pins_t rx_pins
);
    logic [3:0] tx_seen[$];
    // partner sources clocks
    // Both clocks stand still low while run is low
    initial begin
        tx_clock = 1'b0;
        #13;
        forever begin
            #160;
            tx_clock = tx_clock ? 1'b0 : run;
        end
    end
    initial begin
        rx_clock = 1'b0;
        #57;
        forever begin
            #160;
            rx_clock = rx_clock ? 1'b0 : run;
        end
    end
    // capture at rise
    // Takes each driven nibble at the transmit clock rise
    always @(posedge tx_clock) begin
        if (tx_valid === 1'b1) begin
            tx_seen.push_back(tx_nibble);
        end
    end
    // receive launch
    // Launched on the fall so the word is settled at the rise
    task automatic send(input logic [3:0] nib, input logic err);
        @(negedge rx_clock);
        rx_pins <= '{nibble: nib, valid: 1'b1, error: err, collision: 1'b0, carrier: 1'b1};
    endtask : send
    // idle low pins
    // Released lines fall to their pull-downs
    task automatic idle();
        @(negedge rx_clock);
        rx_pins <= '0;
    endtask : idle
    initial rx_pins = '0;
endmodule : spmi_mii_partner

// file: verif/spmi_port_tb.sv
// Self-checking bench for the sixth port: straps, pin status, link traffic.
// Assumes the partner model and the checker are compiled before it.
`timescale 1ns/1ps
module spmi_port_tb
    import spmi_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, run, strap_hi, strap_lo, hreadyout, hresp, txc, rxc;
    logic [1:0] htrans;
    logic [2:0] hsize, pins;
    logic [3:0] strap_nib, nib, nib_oe, nib_pin;
    logic val, val_oe, val_pin;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [7:0] outs;
    spmi_rx_pins_t rxp;
    int miscompares, checks_done;
    logic [4:0] exp_rx[$];
    logic [3:0] exp_tx[$];
    // Strap resistors lose to the port's own drivers
    assign nib_pin = (nib_oe & nib) | (~nib_oe & strap_nib);
    assign val_pin = val_oe ? val : strap_lo;
    spmi_port i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .port_five_tx_clock(txc), .port_five_rx_clock(rxc),
        .port_five_tx_nibble_in(nib_pin), .port_five_tx_nibble(nib),
        .port_five_tx_nibble_oe(nib_oe),
        .port_five_tx_valid_in(val_pin), .port_five_tx_valid(val), .port_five_tx_valid_oe(val_oe),
        .port_five_rx_nibble(rxp.nibble), .port_five_rx_valid(rxp.valid),
        .port_five_rx_error(rxp.error), .port_five_collision(rxp.collision),
        .port_five_carrier(rxp.carrier), .chip_addr_strap_hi(strap_hi),
        .port_five_duplex_in(pins[1]), .port_five_link_in(pins[0]), .port_five_speed_in(pins[2]),
        .flow_ctrl_enable(outs[0]), .serial_mode(outs[1]), .chip_addr(outs[3:2]),
        .small_eeprom_master(outs[4]), .link_up(outs[5]), .full_duplex(outs[6]), .speed_100(outs[7])
    );
    spmi_mii_partner i_mii (
        .run(run), .tx_nibble(nib_pin), .tx_valid(val_pin), .tx_clock(txc), .rx_clock(rxc),
        .rx_pins(rxp)
    );
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic test_done();
        if (miscompares == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : test_done
    // One single AHB-Lite transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h00, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask : bus
    // Status byte from straps {hi, lo, serial, flow} and pins {speed, duplex, link}
    function automatic logic [7:0] exp_st(input logic [3:0] s, input logic [2:0] p);
        return {~p, s[3:2] == 2'h0, s[3:2], s[1:0]};
    endfunction : exp_st
    // the controller's idle serial clock has no pin on this block
    task automatic st_check(input logic [3:0] s);
        logic [7:0] x;
        x = exp_st(s, pins);
        bus(1'b0, SPMI_STATUS, 32'h0);
        check("straps", 32'(rd[4:0]), 32'(x[4:0]));
        check("status", 32'(rd[7:0]), 32'(x));
        check("outputs", 32'(outs), 32'(x));
        check("hresp", 32'(hresp), 32'h0);
    endtask : st_check
    task automatic boot(input logic [3:0] s);
        hresetn <= 1'b0;
        {strap_hi, strap_lo} <= s[3:2];
        strap_nib <= {2'h0, s[1:0]};
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (12) @(posedge hclk);
        st_check(s);
    endtask : boot
    task automatic send_tx(input int n, input logic [3:0] s);
        logic [3:0] v, m;
        m = s[1] ? 4'h1 : 4'hF;
        pins <= 3'h0;
        boot(s);
        i_mii.tx_seen.delete();
        exp_tx.delete();
        run <= 1'b1;
        bus(1'b1, SPMI_CTRL, 32'h1);
        for (int i = 0; i < n; i++) begin
            v = 4'($urandom);
            bus(1'b1, SPMI_TX_DATA, {28'h0, v});
            for (int b = 0; b < 4; b++) begin
                if (s[1]) exp_tx.push_back({3'h0, v[b]});
            end
            if (!s[1]) exp_tx.push_back(v);
        end
        for (int t = 0; t < 4000 && i_mii.tx_seen.size() < exp_tx.size(); t++) @(posedge hclk);
        check("tx count", 32'(i_mii.tx_seen.size()), 32'(exp_tx.size()));
        foreach (exp_tx[i]) begin
            check("tx data", 32'(i_mii.tx_seen[i] & m), 32'(exp_tx[i]));
        end
    endtask : send_tx
    initial begin
        repeat (20000) @(posedge hclk);
        miscompares++;
        test_done();
    end
    initial begin
        logic [3:0] s, v;
        logic e;
        {hsel, hwrite, run, strap_hi, strap_lo, htrans, haddr, hwdata, strap_nib, pins} = '0;
        hresetn = 1'b0;
        hsize = 3'h2;
        miscompares = 0;
        checks_done = 0;
        void'($urandom(32'hd2a601c0));
        // Default and inverted straps, then random ones; pins, strap_hi and strap_nib move after
        for (int k = 0; k < 6; k++) begin
            s = (k == 0) ? 4'h1 : (k == 1) ? 4'hE : 4'($urandom);
            pins <= 3'($urandom);
            boot(s);
            strap_hi <= ~strap_hi;
            strap_nib <= ~strap_nib;
            pins <= 3'($urandom);
            repeat (12) @(posedge hclk);
            st_check(s);
        end
        bus(1'b0, 8'h10, 32'h0);
        check("unmapped", rd, 32'h0);
        send_tx(3, 4'h3);
        send_tx(20, 4'h1);
        bus(1'b0, SPMI_RX_DATA, 32'h0);
        check("rx empty", {31'h0, rd[SPMI_RXD_VALID]}, 32'h0);
        // Receive burst that overruns the buffer, then drain it
        for (int i = 0; i < 20; i++) begin
            v = 4'($urandom);
            e = 1'($urandom);
            i_mii.send(v, e);
            if (i < SPMI_FIFO_DEPTH) exp_rx.push_back({e, v});
        end
        i_mii.idle();
        repeat (8) @(posedge hclk);
        bus(1'b0, SPMI_STATUS, 32'h0);
        check("overflow", {31'h0, rd[SPMI_ST_RX_OVF]}, 32'h1);
        check("carrier idle", {31'h0, rd[SPMI_ST_CRS]}, 32'h0);
        bus(1'b1, SPMI_STATUS, 32'h1 << SPMI_ST_RX_OVF);
        bus(1'b0, SPMI_STATUS, 32'h0);
        check("overflow clear", {31'h0, rd[SPMI_ST_RX_OVF]}, 32'h0);
        foreach (exp_rx[i]) begin
            bus(1'b0, SPMI_RX_DATA, 32'h0);
            check("rx word", {23'h0, rd[8:0]}, {23'h0, 1'b1, 3'h0, exp_rx[i]});
        end
        bus(1'b0, SPMI_RX_DATA, 32'h0);
        check("rx drained", {31'h0, rd[SPMI_RXD_VALID]}, 32'h0);
        test_done();
    end
endmodule : spmi_port_tb
